// [rtl/sp0_pkg.sv]
// serial port zero package: register map, field positions, timing counts and state types
// Summary of operation
// - control bit 7 is upper mode bit or sticky framing-error flag, per select bit
// - mode bits pick sync 8-bit, async 10-bit variable, 11-bit fixed, 11-bit variable
// - modes 2/3 with multiprocessor enable: no receive-done when ninth bit is 0
// - mode 1 with multiprocessor enable: no receive-done without a valid stop bit
// - mode 0: multiprocessor enable picks shift clock oscillator/12 or oscillator/4
// - reception starts only while the receive enable bit is 1; clearing it aborts async frames, mode 0 receive runs on
// - modes 2/3 send the software ninth-bit value as the ninth data bit
// - received ninth bit: ninth bit in modes 2/3, stop bit in mode 1
// - transmit-done set after bit 8 in mode 0, else at stop start; software clears
// - receive-done set after bit 8 in mode 0, else mid stop; software clears
// - data buffer address reads receive buffer and writes transmit buffer
// - serial interrupt needs port enable and global enable; power-fail is never gated
// - set mask bits take part in the address compare; all-zero mask matches anything
package sp0_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
    localparam logic [7:0] IDX_SERIAL_DATA_BUFFER = 8'h99;
    localparam logic [7:0] IDX_INTERRUPT_ENABLE = 8'hA8;
    localparam logic [7:0] IDX_SLAVE_MATCH_ADDRESS = 8'hA9;
    localparam logic [7:0] IDX_ADDRESS_MASK = 8'hB9;
    localparam logic [7:0] IDX_PORT_CONFIG = 8'hE0;
    localparam logic [7:0] IDX_BAUD_DIVISOR = 8'hE1;

    // serial control field positions
    localparam int CTL_MODE_HI = 7;
    localparam int CTL_MODE_LO = 6;
    localparam int CTL_MULTIPROC = 5;
    localparam int CTL_RX_EN = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;

    // interrupt enable and port config field positions
    localparam int IE_GLOBAL = 7;
    localparam int IE_SERIAL = 4;
    localparam int CFG_FRAME_ERR_SELECT = 0;
    localparam int CFG_DOUBLE_RATE = 1;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_CFG = 2'h0;

    // clock counts: mode 0 half bit times, mode 2 oversample tick periods
    localparam logic [7:0] M0_SLOW_HALF = 8'h06;
    localparam logic [7:0] M0_FAST_HALF = 8'h02;
    localparam logic [7:0] M2_TICK_NORMAL = 8'h04;
    localparam logic [7:0] M2_TICK_DOUBLE = 8'h02;
    localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
    localparam logic [4:0] M0_HALF_LAST = 5'h0F;
    localparam logic [4:0] M0_HALF_WAIT = 5'h1F; // wraps to half 0 on the first tick
    localparam logic [3:0] FRAME_LEN_10 = 4'hA;
    localparam logic [3:0] FRAME_LEN_11 = 4'hB;

    // serial modes
    typedef enum logic [1:0] {
        MODE_SYNC8 = 2'b00,
        MODE_ASYNC10 = 2'b01,
        MODE_ASYNC11_FIXED = 2'b10,
        MODE_ASYNC11_VAR = 2'b11
    } sp0_mode_type;

    // asynchronous receive states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10,
        RX_STOP = 2'b11
    } sp0_rx_state_type;

    // tick generator state
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } sp0_tick_state_type;

    // whole state of the port
    typedef struct packed {
        logic mode_hi;
        logic mode_lo;
        logic multiproc_enable;
        logic rx_en;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
        logic frame_err;
        logic [7:0] rx_buf;
        logic [7:0] interrupt_enable;
        logic [7:0] slave_match_address;
        logic [7:0] address_mask;
        logic [1:0] cfg;
        logic [7:0] baud_div;
        logic [31:0] rd_data;
        logic ack;
        logic rxd_s1;
        logic rxd_s2;
        logic rxd_prev;
        logic pf_s1;
        logic pf_s2;
        logic tx_busy;
        logic [10:0] tx_shift;
        logic [3:0] tx_left;
        logic [3:0] tx_sub;
        sp0_rx_state_type rx_st;
        logic [3:0] rx_sub;
        logic [3:0] rx_cnt;
        logic [8:0] rx_shift;
        logic m0_busy;
        logic m0_is_rx;
        logic [4:0] m0_half;
        logic [7:0] m0_shift;
    } sp0_state_type;

endpackage

// [rtl/sp0_serial_port.sv]
// serial port zero with address match, reached over a classic wishbone slave
`timescale 1ns/100ps
module sp0_serial_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rxd_i,
    output logic rxd_o,
    output logic rxd_oe_o,
    output logic txd_o,
    input wire logic powerfail_irq_i,
    output logic serial_irq_o,
    output logic powerfail_irq_o
);

    sp0_pkg::sp0_state_type s_r;
    sp0_pkg::sp0_state_type s_nxt;
    logic tick;
    logic [7:0] idx;
    logic wr;
    logic serial_data_buffer_wr;
    logic [1:0] mode;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic stop_bit;
    logic addr_ok;
    logic accept;
    logic [8:0] shifted;

    assign mode = {s_r.mode_hi, s_r.mode_lo};
    assign idx = adr_i[9:2];

    sp0_tick_gen sp0_tick_gen_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(mode),
        .fast_i(s_r.multiproc_enable),
        .double_rate_i(s_r.cfg[sp0_pkg::CFG_DOUBLE_RATE]),
        .baud_div_i(s_r.baud_div),
        .tick_o(tick)
    );

    // bus strobes: a write lands on the edge where the master sees ack
    assign wr = cyc_i & stb_i & we_i & s_r.ack & sel_i[0];
    assign serial_data_buffer_wr = wr & (idx == sp0_pkg::IDX_SERIAL_DATA_BUFFER);

    // stop-bit evaluation terms of the asynchronous receiver
    always_comb begin
        shifted = {s_r.rxd_s2, s_r.rx_shift[8:1]};
        stop_bit = s_r.rxd_s2;
        rx_data = mode[1] ? s_r.rx_shift[7:0] : s_r.rx_shift[8:1];
        rx_ninth = mode[1] ? s_r.rx_shift[8] : stop_bit;
        addr_ok = ((rx_data ^ s_r.slave_match_address) & s_r.address_mask) == 8'h00;
        accept = 1'b1;
        if (s_r.multiproc_enable) begin
            if (mode[1]) begin
                accept = rx_ninth & addr_ok;
            end else begin
                accept = stop_bit;
            end
        end
    end

    // next state: bus, synchronisers, transmitter, receivers
    always_comb begin
        s_nxt = s_r;
        // pin synchronisers; the first stage feeds only the second
        s_nxt.rxd_s1 = rxd_i;
        s_nxt.rxd_s2 = s_r.rxd_s1;
        s_nxt.rxd_prev = s_r.rxd_s2;
        s_nxt.pf_s1 = powerfail_irq_i;
        s_nxt.pf_s2 = s_r.pf_s1;

        // wishbone answer one cycle after the request, dropped the next cycle
        s_nxt.ack = cyc_i & stb_i & ~s_r.ack;
        if (cyc_i & stb_i & ~s_r.ack) begin
            case (idx)
                sp0_pkg::IDX_SERIAL_CONTROL: s_nxt.rd_data = {24'h000000,
                    (s_r.cfg[sp0_pkg::CFG_FRAME_ERR_SELECT] ? s_r.frame_err : s_r.mode_hi),
                    s_r.mode_lo, s_r.multiproc_enable, s_r.rx_en, s_r.tx_ninth_bit,
                    s_r.rx_ninth_bit, s_r.tx_done_flag, s_r.rx_done_flag};
                sp0_pkg::IDX_SERIAL_DATA_BUFFER: s_nxt.rd_data = {24'h000000, s_r.rx_buf};
                sp0_pkg::IDX_INTERRUPT_ENABLE: s_nxt.rd_data = {24'h000000, s_r.interrupt_enable};
                sp0_pkg::IDX_SLAVE_MATCH_ADDRESS: s_nxt.rd_data = {24'h000000, s_r.slave_match_address};
                sp0_pkg::IDX_ADDRESS_MASK: s_nxt.rd_data = {24'h000000, s_r.address_mask};
                sp0_pkg::IDX_PORT_CONFIG: s_nxt.rd_data = {30'h00000000, s_r.cfg};
                sp0_pkg::IDX_BAUD_DIVISOR: s_nxt.rd_data = {24'h000000, s_r.baud_div};
                default: s_nxt.rd_data = 32'h00000000;
            endcase
        end

        // software register writes; hardware sets further down win over clears
        if (wr) begin
            case (idx)
                sp0_pkg::IDX_SERIAL_CONTROL: begin
                    if (s_r.cfg[sp0_pkg::CFG_FRAME_ERR_SELECT]) begin
                        s_nxt.frame_err = dat_i[sp0_pkg::CTL_MODE_HI];
                    end else begin
                        s_nxt.mode_hi = dat_i[sp0_pkg::CTL_MODE_HI];
                    end
                    s_nxt.mode_lo = dat_i[sp0_pkg::CTL_MODE_LO];
                    s_nxt.multiproc_enable = dat_i[sp0_pkg::CTL_MULTIPROC];
                    s_nxt.rx_en = dat_i[sp0_pkg::CTL_RX_EN];
                    s_nxt.tx_ninth_bit = dat_i[sp0_pkg::CTL_TX_NINTH];
                    s_nxt.rx_ninth_bit = dat_i[sp0_pkg::CTL_RX_NINTH];
                    s_nxt.tx_done_flag = dat_i[sp0_pkg::CTL_TX_DONE];
                    s_nxt.rx_done_flag = dat_i[sp0_pkg::CTL_RX_DONE];
                end
                sp0_pkg::IDX_INTERRUPT_ENABLE: s_nxt.interrupt_enable = dat_i[7:0];
                sp0_pkg::IDX_SLAVE_MATCH_ADDRESS: s_nxt.slave_match_address = dat_i[7:0];
                sp0_pkg::IDX_ADDRESS_MASK: s_nxt.address_mask = dat_i[7:0];
                sp0_pkg::IDX_PORT_CONFIG: s_nxt.cfg = dat_i[1:0];
                sp0_pkg::IDX_BAUD_DIVISOR: s_nxt.baud_div = dat_i[7:0];
                default: ;
            endcase
        end

        // transmit buffer write starts a frame in the current mode
        if (serial_data_buffer_wr) begin
            if (mode == sp0_pkg::MODE_SYNC8) begin
                if (!s_r.m0_busy) begin
                    s_nxt.m0_busy = 1'b1;
                    s_nxt.m0_is_rx = 1'b0;
                    s_nxt.m0_half = sp0_pkg::M0_HALF_WAIT; // align to a tick so the first low half is full
                    s_nxt.m0_shift = dat_i[7:0];
                end
            end else begin
                s_nxt.tx_busy = 1'b1;
                s_nxt.tx_sub = 4'h0;
                if (mode[1]) begin
                    s_nxt.tx_shift = {1'b1, s_r.tx_ninth_bit, dat_i[7:0], 1'b0};
                    s_nxt.tx_left = sp0_pkg::FRAME_LEN_11;
                end else begin
                    s_nxt.tx_shift = {2'b11, dat_i[7:0], 1'b0};
                    s_nxt.tx_left = sp0_pkg::FRAME_LEN_10;
                end
            end
        end else if (s_r.tx_busy && tick) begin
            // asynchronous transmitter: sixteen ticks per bit
            s_nxt.tx_sub = s_r.tx_sub + 4'h1;
            if (s_r.tx_sub == sp0_pkg::OVERSAMPLE_LAST) begin
                s_nxt.tx_shift = {1'b1, s_r.tx_shift[10:1]};
                s_nxt.tx_left = s_r.tx_left - 4'h1;
                if (s_r.tx_left == 4'h2) begin
                    s_nxt.tx_done_flag = 1'b1;
                end
                if (s_r.tx_left == 4'h1) begin
                    s_nxt.tx_busy = 1'b0;
                end
            end
        end

        // mode 0 receive starts when enabled and the previous byte was taken
        if (mode == sp0_pkg::MODE_SYNC8 && !s_r.m0_busy && !serial_data_buffer_wr
            && s_r.rx_en && !s_r.rx_done_flag) begin
            s_nxt.m0_busy = 1'b1;
            s_nxt.m0_is_rx = 1'b1;
            s_nxt.m0_half = sp0_pkg::M0_HALF_WAIT; // align to a tick so the first low half is full
            s_nxt.m0_shift = 8'h00;
        end else if (s_r.m0_busy && tick) begin
            // mode 0 shifter: clock low in even halves, rising at their end
            s_nxt.m0_half = s_r.m0_half + 5'h01;
            if (!s_r.m0_half[0] && s_r.m0_is_rx) begin
                s_nxt.m0_shift = {s_r.rxd_s2, s_r.m0_shift[7:1]};
            end
            if (s_r.m0_half[0] && !s_r.m0_half[4] && !s_r.m0_is_rx) begin
                s_nxt.m0_shift = {1'b0, s_r.m0_shift[7:1]};
            end
            if (s_r.m0_half == sp0_pkg::M0_HALF_LAST) begin
                s_nxt.m0_busy = 1'b0;
                if (s_r.m0_is_rx) begin
                    s_nxt.rx_buf = s_r.m0_shift;
                    s_nxt.rx_done_flag = 1'b1;
                end else begin
                    s_nxt.tx_done_flag = 1'b1;
                end
            end
        end

        // asynchronous receiver, one sample in the middle of each bit
        case (s_r.rx_st)
            sp0_pkg::RX_IDLE: begin
                if (mode != sp0_pkg::MODE_SYNC8 && s_r.rx_en && s_r.rxd_prev && !s_r.rxd_s2) begin
                    s_nxt.rx_st = sp0_pkg::RX_START;
                    s_nxt.rx_sub = 4'h0;
                end
            end
            sp0_pkg::RX_START: begin
                if (tick) begin
                    s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                    if (s_r.rx_sub == sp0_pkg::OVERSAMPLE_MID) begin
                        s_nxt.rx_cnt = 4'h0;
                        s_nxt.rx_st = s_r.rxd_s2 ? sp0_pkg::RX_IDLE : sp0_pkg::RX_BITS;
                    end
                end
            end
            sp0_pkg::RX_BITS: begin
                if (tick) begin
                    s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                    if (s_r.rx_sub == sp0_pkg::OVERSAMPLE_MID) begin
                        s_nxt.rx_shift = shifted;
                        s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
                        if (s_r.rx_cnt == (mode[1] ? 4'h8 : 4'h7)) begin
                            s_nxt.rx_st = sp0_pkg::RX_STOP;
                        end
                    end
                end
            end
            sp0_pkg::RX_STOP: begin
                if (tick) begin
                    s_nxt.rx_sub = s_r.rx_sub + 4'h1;
                    if (s_r.rx_sub == sp0_pkg::OVERSAMPLE_MID) begin
                        s_nxt.rx_st = sp0_pkg::RX_IDLE;
                        if (!stop_bit) begin
                            s_nxt.frame_err = 1'b1;
                        end
                        if (accept && !s_r.rx_done_flag) begin
                            s_nxt.rx_buf = rx_data;
                            s_nxt.rx_ninth_bit = rx_ninth;
                            s_nxt.rx_done_flag = 1'b1;
                        end
                    end
                end
            end
            default: s_nxt.rx_st = sp0_pkg::RX_IDLE;
        endcase

        // leaving the receive enable aborts an asynchronous frame in progress; a mode 0 receive runs on
        if (!s_r.rx_en) begin
            s_nxt.rx_st = sp0_pkg::RX_IDLE;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.rxd_s1 <= 1'b1;
            s_r.rxd_s2 <= 1'b1;
            s_r.rxd_prev <= 1'b1;
            s_r.tx_shift <= 11'h7FF;
            s_r.rx_st <= sp0_pkg::RX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign dat_o = s_r.rd_data;
    assign ack_o = s_r.ack;
    assign txd_o = s_r.m0_busy ? s_r.m0_half[0] : (s_r.tx_busy ? s_r.tx_shift[0] : 1'b1);
    assign rxd_o = s_r.m0_shift[0];
    assign rxd_oe_o = s_r.m0_busy & ~s_r.m0_is_rx;
    assign serial_irq_o = s_r.interrupt_enable[sp0_pkg::IE_GLOBAL] & s_r.interrupt_enable[sp0_pkg::IE_SERIAL]
                          & (s_r.tx_done_flag | s_r.rx_done_flag);
    assign powerfail_irq_o = s_r.pf_s2;

endmodule

// [rtl/sp0_tick_gen.sv]
// tick generator: half bit ticks in mode 0, sixteen-times oversample ticks otherwise
`timescale 1ns/100ps
module sp0_tick_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] mode_i,
    input wire logic fast_i,
    input wire logic double_rate_i,
    input wire logic [7:0] baud_div_i,
    output logic tick_o
);

    sp0_pkg::sp0_tick_state_type st_r;
    sp0_pkg::sp0_tick_state_type st_nxt;
    logic [7:0] period;

    // period in clocks per tick for the selected mode
    always_comb begin
        case (mode_i)
            sp0_pkg::MODE_SYNC8: period = fast_i ? sp0_pkg::M0_FAST_HALF : sp0_pkg::M0_SLOW_HALF;
            sp0_pkg::MODE_ASYNC11_FIXED: period = double_rate_i ? sp0_pkg::M2_TICK_DOUBLE
                                                               : sp0_pkg::M2_TICK_NORMAL;
            default: period = baud_div_i + 8'h01;
        endcase
    end

    // free running counter, one tick per period
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt >= period - 8'h01) begin
            st_nxt.cnt = 8'h00;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;

endmodule

// [verif/sp0_chk.sv]
// checker: bus handshake, interrupt gating, transmit start and mode 0 clock timing
`timescale 1ns/100ps
module sp0_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic rxd_oe_o,
    input wire logic txd_o,
    input wire logic powerfail_irq_i,
    input wire logic serial_irq_o,
    input wire logic powerfail_irq_o
);
    logic mhi_r, mlo_r, mp_r, fes_r, wr, m0, dbw;
    logic [7:0] ie_r;
    // shadow of mode, enable and select bits as software wrote them
    assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign m0 = !mhi_r && !mlo_r;
    assign dbw = wr && adr_i[9:2] == sp0_pkg::IDX_SERIAL_DATA_BUFFER;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {mhi_r, mlo_r, mp_r, fes_r, ie_r} <= 12'h000;
        end else if (wr) begin
            if (adr_i[9:2] == sp0_pkg::IDX_SERIAL_CONTROL) begin
                mhi_r <= fes_r ? mhi_r : dat_i[7];
                mlo_r <= dat_i[6];
                mp_r <= dat_i[5];
            end
            if (adr_i[9:2] == sp0_pkg::IDX_INTERRUPT_ENABLE) begin
                ie_r <= dat_i[7:0];
            end
            if (adr_i[9:2] == sp0_pkg::IDX_PORT_CONFIG) begin
                fes_r <= dat_i[0];
            end
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
    AST_IRQ_GATE: assert property (serial_irq_o |-> ie_r[7] && ie_r[4])
        else $error("serial irq not gated");
    AST_IRQ_OR: assert property (ack_o && !we_i && adr_i[9:2] == sp0_pkg::IDX_SERIAL_CONTROL
        && dat_o[1:0] != 2'h0 && ie_r[7] && ie_r[4] |-> serial_irq_o) else $error("flag without irq");
    AST_PF_HI: assert property (powerfail_irq_i [*3] |-> powerfail_irq_o)
        else $error("power-fail irq missing");
    AST_PF_LO: assert property (!powerfail_irq_i [*3] |-> !powerfail_irq_o)
        else $error("power-fail irq stuck");
    AST_OE_M0: assert property (rxd_oe_o |-> m0) else $error("data pin driven outside mode 0");
    AST_TX_START: assert property (dbw && !m0 |=> ##[0:20] !txd_o)
        else $error("no start bit after buffer write");
    AST_M0_SLOW: assert property (m0 && !mp_r && $fell(txd_o) |-> !txd_o [*6] ##1 txd_o)
        else $error("slow shift clock low phase wrong");
    AST_M0_FAST: assert property (m0 && mp_r && $fell(txd_o) |-> !txd_o [*2] ##1 txd_o)
        else $error("fast shift clock low phase wrong");
    // main scenarios reached
    cover property (dbw && !m0);
    cover property ($rose(serial_irq_o));
    cover property ($rose(rxd_oe_o));
endmodule
bind sp0_serial_port sp0_chk sp0_chk_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .powerfail_irq_i(powerfail_irq_i),
    .serial_irq_o(serial_irq_o), .powerfail_irq_o(powerfail_irq_o));

// [verif/sp0_remote.sv]
// remote serial station: sends async frames, samples async and mode 0 frames
`timescale 1ns/100ps
module sp0_remote (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic data_i,
    output logic line_o
);
    // line idles high as with a pull-up
    initial line_o = 1'b1;
    // one frame lsb first, per clocks a bit
    task automatic send(input int per, input int nb, input logic [10:0] fr);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk_i);
            line_o <= fr[i];
            repeat (per - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask
    // sample each bit at its middle, counted from the start edge
    task automatic recv(input int per, input int nb, output logic [10:0] fr);
        fr = 11'h7FF;
        while (txd_i !== 1'b0) @(posedge clk_i);
        repeat (per / 2) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            fr[i] = txd_i;
            repeat (per) @(posedge clk_i);
        end
    endtask
    // mode 0: data is settled half a clock into each low phase
    task automatic m0_recv(output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd_i);
            @(negedge clk_i);
            d[i] = data_i;
        end
    endtask
endmodule

// [verif/sp0_serial_port_test.sv]
// testbench: register access, transmit in every mode, receive in modes 0, 1 and 3, address match
`timescale 1ns/100ps
module sp0_serial_port_test;
    localparam logic [7:0] CTL = sp0_pkg::IDX_SERIAL_CONTROL;
    localparam logic [7:0] DBUF = sp0_pkg::IDX_SERIAL_DATA_BUFFER;
    localparam logic [7:0] IEN = sp0_pkg::IDX_INTERRUPT_ENABLE;
    localparam logic [7:0] SAD = sp0_pkg::IDX_SLAVE_MATCH_ADDRESS;
    localparam logic [7:0] MSK = sp0_pkg::IDX_ADDRESS_MASK;
    localparam logic [7:0] CFG = sp0_pkg::IDX_PORT_CONFIG;
    logic clk, rst, cyc, stb, we, pf;
    logic [9:0] adr;
    logic [31:0] dat;
    logic [31:0] dat_o;
    logic ack, rxd_o, oe, txd, sirq, pirq, line, rxd;
    logic [7:0] rd;
    logic [10:0] fr;
    int n_mismatch = 0;
    int checks_done = 0;
    // pin level: device drive wins, else the remote line
    assign rxd = oe ? rxd_o : line;
    sp0_serial_port sp0_serial_port_i (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .rxd_i(rxd), .rxd_o(rxd_o),
        .rxd_oe_o(oe), .txd_o(txd), .powerfail_irq_i(pf), .serial_irq_o(sirq), .powerfail_irq_o(pirq));
    sp0_remote sp0_remote_i (.clk_i(clk), .txd_i(txd), .data_i(rxd), .line_o(line));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic [7:0] ix, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, ix, 2'h0, 24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        q = dat_o[7:0];
        {cyc, stb, we} <= 3'h0;
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic [7:0] q;
        wb(ix, 1'b1, d, q);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] ix, input logic [7:0] m, input logic [7:0] exp);
        logic [7:0] q;
        wb(ix, 1'b0, 8'h00, q);
        chk(q & m, exp);
    endtask
    function automatic logic [10:0] frm(input logic [7:0] d, input logic n, input logic s, input int nb);
        return {s, (nb == 11) ? n : s, d, 1'b0};
    endfunction
    // set control, then the remote sends one frame at 16 clocks a bit
    task automatic rxf(input logic [7:0] c, input int nb, input logic [7:0] d, input logic n, input logic s);
        wr(CTL, c);
        sp0_remote_i.send(16, nb, frm(d, n, s, nb));
        repeat (16) @(posedge clk);
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        logic [7:0] ixs[6] = '{CTL, DBUF, IEN, SAD, MSK, 8'h10};
        logic [7:0] cs[4] = '{8'h40, 8'h80, 8'h80, 8'hC8};
        int ps[4] = '{16, 64, 32, 16};
        int nbs[4] = '{10, 11, 11, 11};
        logic [7:0] ad[4] = '{8'h12, 8'h34, 8'h12, 8'h77};
        logic [7:0] ex[4] = '{8'h00, 8'h00, 8'h01, 8'h01};
        {cyc, stb, we, adr, dat, pf, rst} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped place ignored, read-write registers
        foreach (ixs[k]) rdchk(ixs[k], 8'hFF, 8'h00);
        wr(8'h10, 8'hFF);
        rdchk(8'h10, 8'hFF, 8'h00);
        wr(SAD, 8'h5A);
        rdchk(SAD, 8'hFF, 8'h5A);
        wr(MSK, 8'hA5);
        rdchk(MSK, 8'hFF, 8'hA5);
        // power-fail request passes with every enable off
        @(posedge clk);
        pf <= 1'b1;
        repeat (4) @(posedge clk);
        chk({7'h0, pirq}, 8'h01);
        pf <= 1'b0;
        // transmit in modes 1, 2, 2 at double rate, 3 with ninth bit set
        wr(sp0_pkg::IDX_BAUD_DIVISOR, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(CFG, (k == 2) ? 8'h02 : 8'h00);
            wr(CTL, cs[k]);
            fork
                sp0_remote_i.recv(ps[k], nbs[k], fr);
                wr(DBUF, 8'h3C + k);
            join
            chk(fr[8:1], 8'h3C + k);
            chk({5'h0, fr[10:9], fr[0]}, {6'h1, (nbs[k] == 10) | cs[k][3], 1'b0});
            rdchk(CTL, 8'h02, 8'h02);
        end
        wr(CFG, 8'h00);
        // mode 0 transmit at slow and fast shift clock
        for (int k = 0; k < 2; k++) begin
            wr(CTL, (k == 1) ? 8'h20 : 8'h00);
            fork
                sp0_remote_i.m0_recv(rd);
                wr(DBUF, 8'h96 + k);
            join
            chk(rd, 8'h96 + k);
            repeat (12) @(posedge clk);
            rdchk(CTL, 8'h02, 8'h02);
        end
        // mode 0 receive at fast shift clock, idle-high line gives all ones
        wr(CTL, 8'h30);
        repeat (60) @(posedge clk);
        rdchk(CTL, 8'h01, 8'h01);
        rdchk(DBUF, 8'hFF, 8'hFF);
        // mode 1 receive, interrupt enabled then globally masked
        rxf(8'h50, 10, 8'hC3, 1'b0, 1'b1);
        rdchk(CTL, 8'h05, 8'h05);
        rdchk(DBUF, 8'hFF, 8'hC3);
        wr(IEN, 8'h90);
        @(negedge clk);
        chk({7'h0, sirq}, 8'h01);
        rdchk(CTL, 8'h01, 8'h01);
        wr(IEN, 8'h10);
        @(negedge clk);
        chk({7'h0, sirq}, 8'h00);
        // reception disabled
        rxf(8'h40, 10, 8'h55, 1'b0, 1'b1);
        rdchk(CTL, 8'h01, 8'h00);
        // bad stop with multiprocessor enable: no receive, frame error shown
        wr(CFG, 8'h01);
        rxf(8'h70, 10, 8'h66, 1'b0, 1'b0);
        rdchk(CTL, 8'h81, 8'h80);
        wr(CTL, 8'h70);
        rdchk(CTL, 8'h80, 8'h00);
        wr(CFG, 8'h00);
        // mode 3 address match: ninth 0, wrong address, match, all-zero mask
        wr(SAD, 8'h12);
        wr(MSK, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            if (k == 3) wr(MSK, 8'h00);
            rxf(8'hF0, 11, ad[k], k != 0, 1'b1);
            rdchk(CTL, 8'h01, ex[k]);
        end
        rdchk(DBUF, 8'hFF, 8'h77);
        rdchk(CTL, 8'h04, 8'h04);
        summarize();
    end
endmodule
